/* verilog/lfm_pkg.sv */
package lfm_pkg;

  localparam int NCH = 4;
  localparam int CHAR_W = 10;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] CHAR01_OFS = 12'h008;
  localparam logic [11:0] CHAR23_OFS = 12'h00C;

  // control field positions
  localparam int LIS_LSB = 0;
  localparam int LPB_LSB = 4;
  localparam int PWR_LSB = 8;
  localparam int OVR_LSB = 12;
  localparam int FEN_LSB = 16;
  localparam int FPS_LSB = 20;
  localparam int RAT_LSB = 24;
  localparam int AMP_LSB = 28;

  // status field positions
  localparam int ST_LFI_LSB = 0;
  localparam int ST_FRC_LSB = 4;
  localparam int ST_OOR_LSB = 8;
  localparam int ST_TRN_LSB = 12;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // amplitude threshold codes
  localparam logic [1:0] AMP_OFF = 2'h0;

  // transition detector: six characters
  localparam int TRANS_MAX_BITS = 60;
  localparam logic [6:0] TRANS_LIMIT = 7'd60;

  // range control
  localparam int RANGE_PERIOD = 4096;
  localparam logic [11:0] RANGE_LAST = 12'hFFF;
  localparam int RANGE_PPM = 1500;
  // reference ticks expected per interval, full and half character rate
  localparam logic [12:0] REF_EXP_DIV10 = 13'h1000;
  localparam logic [12:0] REF_EXP_DIV20 = 13'h0800;
  localparam logic [12:0] REF_TOL_DIV10 = 13'(RANGE_PERIOD * RANGE_PPM / 1000000);
  localparam logic [12:0] REF_TOL_DIV20 = 13'(RANGE_PERIOD * RANGE_PPM / 2000000);

  // framing patterns, oldest bit in bit 0
  localparam logic [7:0] COMMA_POS = 8'h7C;
  localparam logic [7:0] COMMA_NEG = 8'h83;
  localparam logic [9:0] K285_NEG = 10'h17C;
  localparam logic [9:0] K285_POS = 10'h283;
  localparam logic [3:0] BIT_LAST = 4'h9;

  typedef enum logic [1:0] {
    LFM_RC_MEASURE = 2'b01,
    LFM_RC_FORCE = 2'b10
  } lfm_rc_state_t;

endpackage

/* verilog/lfm_range_ctl.sv */
`timescale 1ns/10ps
`default_nettype none
module lfm_range_ctl (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic enable, // channel powered
  input wire logic ratio, // 1: reference at bit rate / 20
  input wire logic byte_tick, // recovered byte clock pulse
  input wire logic ref_tick, // reference clock pulse
  output logic force_ref, // oscillator held on reference
  output logic out_of_range // last interval outside tolerance
);

  lfm_pkg::lfm_rc_state_t st_r, st_nxt;
  logic [11:0] byte_cnt_r, byte_cnt_nxt;
  logic [12:0] ref_cnt_r, ref_cnt_nxt;
  logic oor_r, oor_nxt;
  logic [12:0] exp_cnt;
  logic [12:0] tol;
  logic [12:0] diff;
  logic end_win;

  assign exp_cnt = ratio ? lfm_pkg::REF_EXP_DIV20 : lfm_pkg::REF_EXP_DIV10;
  assign tol = ratio ? lfm_pkg::REF_TOL_DIV20 : lfm_pkg::REF_TOL_DIV10;
  assign diff = (ref_cnt_r > exp_cnt) ? ref_cnt_r - exp_cnt
                                      : exp_cnt - ref_cnt_r;
  assign end_win = byte_tick && (byte_cnt_r == lfm_pkg::RANGE_LAST);

  always_comb begin
    st_nxt = st_r;
    byte_cnt_nxt = byte_cnt_r;
    ref_cnt_nxt = ref_cnt_r;
    oor_nxt = oor_r;
    if (!enable) begin
      st_nxt = lfm_pkg::LFM_RC_MEASURE;
      byte_cnt_nxt = 12'h000;
      ref_cnt_nxt = 13'h0000;
      oor_nxt = 1'b0;
    end else begin
      if (byte_tick) begin
        byte_cnt_nxt = byte_cnt_r + 12'h001;
      end
      // saturate so a slow byte clock still reads as out of range
      if (ref_tick && ref_cnt_r != 13'h1FFF) begin
        ref_cnt_nxt = ref_cnt_r + 13'h0001;
      end
      case (st_r)
        lfm_pkg::LFM_RC_MEASURE: begin
          if (end_win) begin
            ref_cnt_nxt = 13'h0000;
            oor_nxt = diff > tol;
            if (diff > tol) begin
              st_nxt = lfm_pkg::LFM_RC_FORCE;
            end
          end
        end
        lfm_pkg::LFM_RC_FORCE: begin
          // held one interval on the reference, then released
          if (end_win) begin
            ref_cnt_nxt = 13'h0000;
            st_nxt = lfm_pkg::LFM_RC_MEASURE;
          end
        end
        default: begin
          st_nxt = lfm_pkg::LFM_RC_MEASURE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= lfm_pkg::LFM_RC_MEASURE;
      byte_cnt_r <= 12'h000;
      ref_cnt_r <= 13'h0000;
      oor_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      oor_r <= oor_nxt;
    end
  end

  assign force_ref = (st_r == lfm_pkg::LFM_RC_FORCE);
  assign out_of_range = oor_r;

endmodule // lfm_range_ctl
`default_nettype wire

/* verilog/lfm_framer.sv */
`timescale 1ns/10ps
`default_nettype none
module lfm_framer (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic bit_in, // recovered bit, one per clock
  input wire logic enable, // framer allowed to move boundary
  input wire logic full_k, // 1: full ten-bit pattern only
  output logic [9:0] char_out, // last framed character
  output logic char_valid // one-cycle pulse per character
);

  logic [9:0] sh_r, sh_nxt;
  logic [3:0] pos_r, pos_nxt;
  logic [9:0] chr_r, chr_nxt;
  logic vld_r, vld_nxt;
  logic hit;

  always_comb begin
    sh_nxt = {bit_in, sh_r[9:1]};
    if (full_k) begin
      hit = (sh_nxt == lfm_pkg::K285_NEG) || (sh_nxt == lfm_pkg::K285_POS);
    end else begin
      hit = (sh_nxt[7:0] == lfm_pkg::COMMA_POS) ||
            (sh_nxt[7:0] == lfm_pkg::COMMA_NEG);
    end
    pos_nxt = (pos_r == lfm_pkg::BIT_LAST) ? 4'h0 : pos_r + 4'h1;
    chr_nxt = chr_r;
    vld_nxt = 1'b0;
    // a disabled framer never moves the boundary
    // the pattern starts at the oldest bit of the window, so the next character starts afresh
    if (enable && hit) begin
      pos_nxt = 4'h0;
    end
    if (pos_r == lfm_pkg::BIT_LAST) begin
      chr_nxt = sh_nxt;
      vld_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= 10'h000;
      pos_r <= 4'h0;
      chr_r <= 10'h000;
      vld_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      pos_r <= pos_nxt;
      chr_r <= chr_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign char_out = chr_r;
  assign char_valid = vld_r;

endmodule // lfm_framer
`default_nettype wire

/* verilog/lfm_monitor.sv */
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Function
// - each channel sends one of two serial inputs to recovery, by select
// - loopback feeds transmit stream to recovery, holds transmit output at one
// - link good only if amplitude, transitions, range, enable, refclock, no override
// - link fault output changes only on the receive interface clock
// - threshold code zero disables detector, higher codes raise the trip level
// - one amplitude threshold setting serves all channels
// - in loopback, no input selected, amplitude ignored, range and transitions only
// - no transition for more than sixty bits flags a fault
// - range control compares oscillator to reference, forces on excess deviation
// - range control interval is 4096 recovered byte clocks
// - link fault output low while oscillator is held on reference
// - lock may take one interval, fault output then goes high
// - power enable zero powers channel down and holds the fault state
// - reference is bit rate over 10 or 20 per clock ratio
// - out of range tracks reference, then returns to tracking data
// - bits shift into deserializer; framer searches every position for pattern
// - pattern select zero matches eight-bit comma, one matches full K28.5
// - cleared framer enable keeps character boundaries unchanged
module lfm_monitor (
  input wire logic pclk, // bit-rate receive clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [3:0] serial_input_primary, // primary serial bit
  input wire logic [3:0] serial_input_secondary, // secondary serial bit
  input wire logic [3:0] tx_serial_in, // transmit shifter bit
  output logic [3:0] tx_serial_out, // serial transmit bit
  input wire logic [7:0] amp_level, // 2-bit amplitude level per channel
  input wire logic [3:0] ref_present, // reference clock seen, async
  input wire logic [3:0] byte_tick, // recovered byte clock pulse
  input wire logic [3:0] ref_tick, // reference clock pulse
  output logic [3:0] link_fault_indicator_n, // low on link fault
  output logic [3:0] track_reference, // oscillator forced to reference
  output logic [3:0] channel_power_on, // analog and loop powered
  output logic [3:0] amp_monitor_enable, // analog detector active
  output logic [1:0] amplitude_threshold_select, // shared trip level
  output logic [3:0] clock_ratio_select, // 1: reference at bit rate / 20
  output logic [3:0] recovery_bit // bit into recovery loop
);

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic err_r, err_nxt;
  logic [31:0] status;
  logic [39:0] chars;
  logic wr_en;
  logic setup;

  logic [3:0] line_input_select;
  logic [3:0] local_loopback_enable;
  logic [3:0] rx_channel_power_enable;
  logic [3:0] link_override_control;
  logic [3:0] framer_enable_latch;
  logic [3:0] framing_pattern_select;

  assign line_input_select = ctrl_r[lfm_pkg::LIS_LSB +: 4];
  assign local_loopback_enable = ctrl_r[lfm_pkg::LPB_LSB +: 4];
  assign rx_channel_power_enable = ctrl_r[lfm_pkg::PWR_LSB +: 4];
  assign link_override_control = ctrl_r[lfm_pkg::OVR_LSB +: 4];
  assign framer_enable_latch = ctrl_r[lfm_pkg::FEN_LSB +: 4];
  assign framing_pattern_select = ctrl_r[lfm_pkg::FPS_LSB +: 4];

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    if (wr_en && paddr == lfm_pkg::CTRL_OFS) begin
      ctrl_nxt = pwdata;
    end
    // decode in setup so data and error stand ready at the access phase
    if (setup) begin
      err_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      case (paddr)
        lfm_pkg::CTRL_OFS: rdata_nxt = ctrl_r;
        lfm_pkg::STAT_OFS: rdata_nxt = pwrite ? 32'h0000_0000 : status;
        lfm_pkg::CHAR01_OFS: rdata_nxt = {12'h000, chars[19:0]};
        lfm_pkg::CHAR23_OFS: rdata_nxt = {12'h000, chars[39:20]};
        default: err_nxt = 1'b1;
      endcase
      if (pwrite) begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= lfm_pkg::CTRL_RST;
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata = rdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_r;

  assign amplitude_threshold_select = ctrl_r[lfm_pkg::AMP_LSB +: 2];
  assign clock_ratio_select = ctrl_r[lfm_pkg::RAT_LSB +: 4];
  assign channel_power_on = rx_channel_power_enable;

  ////////////////////////////////////////////////////////////////////////
  // per-channel datapath

  logic [3:0] lfi_ok_r, lfi_ok_nxt;
  logic [3:0] txo_r, txo_nxt;
  logic [3:0] rbit_r, rbit_nxt;
  logic [3:0] prev_r, prev_nxt;
  logic [6:0] run_r [4];
  logic [6:0] run_nxt [4];
  logic [3:0] trans_fault;
  logic [3:0] ref_meta_r, ref_sync_r;
  logic [3:0] force_ref;
  logic [3:0] oor;
  logic [3:0] amp_ok;
  logic [3:0] char_valid;

  genvar g;
  generate
    for (g = 0; g < lfm_pkg::NCH; g++) begin : g_ch
      logic sel_bit;

      always_comb begin
        if (local_loopback_enable[g]) begin
          sel_bit = tx_serial_in[g];
        end else if (line_input_select[g]) begin
          sel_bit = serial_input_secondary[g];
        end else begin
          sel_bit = serial_input_primary[g];
        end
        rbit_nxt[g] = sel_bit;
        prev_nxt[g] = rbit_r[g];
        // hold a constant one so diagnostics never leave the chip
        txo_nxt[g] = local_loopback_enable[g] ? 1'b1 : tx_serial_in[g];
        run_nxt[g] = run_r[g];
        if (!rx_channel_power_enable[g] || rbit_r[g] != prev_r[g]) begin
          run_nxt[g] = 7'd0;
        end else if (run_r[g] != 7'h7F) begin
          run_nxt[g] = run_r[g] + 7'd1;
        end
      end

      assign trans_fault[g] = run_r[g] >= lfm_pkg::TRANS_LIMIT;

      assign amp_monitor_enable[g] = rx_channel_power_enable[g] &&
        !local_loopback_enable[g] &&
        amplitude_threshold_select != lfm_pkg::AMP_OFF;
      // analog comparator result against the shared threshold
      assign amp_ok[g] = !amp_monitor_enable[g] ||
        amp_level[2*g +: 2] >= amplitude_threshold_select;

      always_comb begin
        if (local_loopback_enable[g]) begin
          lfi_ok_nxt[g] = rx_channel_power_enable[g] && !oor[g] &&
                          !force_ref[g] && !trans_fault[g];
        end else begin
          lfi_ok_nxt[g] = amp_ok[g] && !trans_fault[g] && !oor[g] &&
                          rx_channel_power_enable[g] && ref_sync_r[g] &&
                          !link_override_control[g];
        end
        // forced tracking always reads as a fault
        if (force_ref[g]) begin
          lfi_ok_nxt[g] = 1'b0;
        end
        if (!rx_channel_power_enable[g]) begin
          lfi_ok_nxt[g] = 1'b0;
        end
      end

      lfm_range_ctl u_range (
        .pclk(pclk),
        .presetn(presetn),
        .enable(rx_channel_power_enable[g]),
        .ratio(clock_ratio_select[g]),
        .byte_tick(byte_tick[g]),
        .ref_tick(ref_tick[g]),
        .force_ref(force_ref[g]),
        .out_of_range(oor[g])
      );

      // input swaps need no special handling: the framer reacquires
      lfm_framer u_framer (
        .pclk(pclk),
        .presetn(presetn),
        .bit_in(rbit_r[g]),
        .enable(framer_enable_latch[g]),
        .full_k(framing_pattern_select[g]),
        .char_out(chars[10*g +: 10]),
        .char_valid(char_valid[g])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          run_r[g] <= 7'd0;
        end else begin
          run_r[g] <= run_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfi_ok_r <= 4'h0;
      txo_r <= 4'h0;
      rbit_r <= 4'h0;
      prev_r <= 4'h0;
      ref_meta_r <= 4'h0;
      ref_sync_r <= 4'h0;
    end else begin
      lfi_ok_r <= lfi_ok_nxt;
      txo_r <= txo_nxt;
      rbit_r <= rbit_nxt;
      prev_r <= prev_nxt;
      ref_meta_r <= ref_present;
      ref_sync_r <= ref_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign link_fault_indicator_n = lfi_ok_r;
  assign tx_serial_out = txo_r;
  assign recovery_bit = rbit_r;
  assign track_reference = force_ref;

  assign status = {16'h0000, trans_fault, oor, force_ref, lfi_ok_r};

endmodule // lfm_monitor
`default_nettype wire

/* tb/lfm_remote_tx.sv */
`timescale 1ns/10ps
`default_nettype none
module lfm_remote_tx (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic still, // 1: primary line stuck, no transitions on it
  input wire logic ref_on, // 1: reference clock running
  output logic [3:0] pri, // primary serial bits
  output logic [3:0] sec, // secondary serial bits
  output logic [3:0] byte_tick, // byte clock pulse
  output logic [3:0] ref_tick // reference clock pulse
);
  logic dat_r, dat_nxt;
  logic [1:0] cyc_r, cyc_nxt;
  always_comb begin
    dat_nxt = still ? dat_r : !dat_r;
    cyc_nxt = cyc_r + 2'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_r <= 1'b0;
      cyc_r <= 2'h0;
    end else begin
      dat_r <= dat_nxt;
      cyc_r <= cyc_nxt;
    end
  end
  // two different patterns so a wrong input choice shows
  // secondary keeps toggling when the primary line sticks
  assign pri = {4{dat_r}};
  assign sec = {4{cyc_r[1]}};
  assign byte_tick = {4{cyc_r == 2'h0}};
  // one reference pulse per byte: divide-by-ten ratio
  assign ref_tick = ref_on ? byte_tick : 4'h0;
endmodule // lfm_remote_tx
`default_nettype wire

/* tb/lfm_monitor_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module lfm_monitor_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [3:0] serial_input_primary, // primary bit
  input wire logic [3:0] serial_input_secondary, // secondary bit
  input wire logic [3:0] tx_serial_out, // transmit bit
  input wire logic [3:0] byte_tick, // byte clock pulse
  input wire logic [3:0] link_fault_indicator_n, // low on fault
  input wire logic [3:0] track_reference, // forced to reference
  input wire logic [3:0] channel_power_on, // channel powered
  input wire logic [3:0] amp_monitor_enable, // detector active
  input wire logic [1:0] amplitude_threshold_select, // trip level
  input wire logic [3:0] recovery_bit // bit into recovery
);
  logic [31:0] ctl_r, ctl_nxt;
  logic [3:0] exp_r, exp_nxt;
  logic last_r, last_nxt;
  logic [6:0] run_r, run_nxt;
  logic [12:0] span_r, span_nxt;
  always_comb begin
    ctl_nxt = ctl_r;
    if (psel && penable && pwrite && paddr == lfm_pkg::CTRL_OFS) begin
      ctl_nxt = pwdata;
    end
    exp_nxt = (serial_input_primary & ~ctl_r[3:0])
      | (serial_input_secondary & ctl_r[3:0]);
    last_nxt = recovery_bit[0];
    // saturates so a stuck line keeps flagging
    run_nxt = (recovery_bit[0] != last_r) ? 7'h00
      : run_r + {6'h00, run_r != 7'h7F};
    span_nxt = track_reference[0] ? span_r + {12'h000, byte_tick[0]}
      : 13'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 32'h0000_0000;
      exp_r <= 4'h0;
      last_r <= 1'b0;
      run_r <= 7'h00;
      span_r <= 13'h0000;
    end else begin
      ctl_r <= ctl_nxt;
      exp_r <= exp_nxt;
      last_r <= last_nxt;
      run_r <= run_nxt;
      span_r <= span_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_input_route: assert property (((recovery_bit ^ exp_r)
    & $past(ctl_r[11:8] & ~ctl_r[7:4])) == 4'h0)
    else $error("recovered bit not from selected input");
  a_loop_one: assert property ((~tx_serial_out & $past(ctl_r[7:4])) == 4'h0)
    else $error("loopback transmit not held at one");
  a_amp_enable: assert property (amplitude_threshold_select
    == ctl_r[29:28] && amp_monitor_enable == (channel_power_on
    & ~ctl_r[7:4] & {4{ctl_r[29:28] != 2'h0}}))
    else $error("amplitude detector control wrong");
  a_override_fault: assert property ((link_fault_indicator_n
    & $past(ctl_r[15:12] & ~ctl_r[7:4])) == 4'h0)
    else $error("link good under override");
  a_power_fault: assert property ((link_fault_indicator_n
    & ~$past(channel_power_on)) == 4'h0)
    else $error("link good while powered down");
  a_force_fault: assert property ((link_fault_indicator_n
    & $past(track_reference)) == 4'h0)
    else $error("link good while forced to reference");
  a_run_fault: assert property (run_r >= 7'd61
    |-> !link_fault_indicator_n[0])
    else $error("no fault after long run without transitions");
  a_force_span: assert property ($fell(track_reference[0])
    && channel_power_on[0] |-> span_r >= 13'd4095 && span_r <= 13'd4097)
    else $error("forced span not one interval");
  a_apb_err: assert property (psel && penable |-> pready
    && pslverr == (paddr > lfm_pkg::CHAR23_OFS))
    else $error("apb ready or error wrong");
  c_force: cover property ($rose(track_reference[0]));
  c_run: cover property (run_r >= 7'd64);
  c_err: cover property (psel && penable && pslverr);
endmodule // lfm_monitor_checker
bind lfm_monitor lfm_monitor_checker chk_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .serial_input_primary, .serial_input_secondary, .tx_serial_out,
  .byte_tick, .link_fault_indicator_n, .track_reference, .channel_power_on,
  .amp_monitor_enable, .amplitude_threshold_select, .recovery_bit);
`default_nettype wire

/* tb/test_rx_link_fault_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module test_rx_link_fault_monitor;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic still, ref_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pri, sec, txi, txo, refp, bt, rt, lfi, trk, pwr, ame, rat;
  logic [3:0] rbit, e;
  logic [7:0] amp;
  logic [1:0] thr;
  int error_cnt, checked, n;
  lfm_monitor dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_input_primary(pri),
    .serial_input_secondary(sec), .tx_serial_in(txi), .tx_serial_out(txo),
    .amp_level(amp), .ref_present(refp), .byte_tick(bt), .ref_tick(rt),
    .link_fault_indicator_n(lfi), .track_reference(trk),
    .channel_power_on(pwr), .amp_monitor_enable(ame),
    .amplitude_threshold_select(thr), .clock_ratio_select(rat),
    .recovery_bit(rbit));
  lfm_remote_tx far (.pclk, .presetn, .still, .ref_on, .pri, .sec,
    .byte_tick(bt), .ref_tick(rt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // called just after a rising edge; returns one idle cycle later
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_lfi(input logic [3:0] x, input int lim);
    n = 0;
    while (lfi !== x && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({28'h0, lfi}, {28'h0, x});
  endtask
  task automatic t_reset();
    chk({24'h0, lfi, txo}, 32'h0000_0000);
    apb(1'b0, lfm_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, lfm_pkg::STAT_OFS, 32'hFFFF_FFFF);
    apb(1'b0, lfm_pkg::STAT_OFS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_route();
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h0000_0F0A);
    for (int i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (i > 0) begin
        chk({28'h0, rbit}, {28'h0, e});
      end
      e = (pri & ~4'hA) | (sec & 4'hA);
    end
  endtask
  task automatic t_amp();
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, lfm_pkg::CTRL_OFS, {2'h0, 2'(c), 28'h0000_F40});
      repeat (2) @(posedge pclk);
      chk({30'h0, thr}, 32'(c));
      chk({28'h0, ame}, (c == 0) ? 32'h0 : 32'hB);
      chk({28'h0, txo}, 32'h4);
    end
  endtask
  task automatic t_link();
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h1000_0F00);
    wait_lfi(4'hF, 17000);
    amp <= 8'hFC;
    refp <= 4'h7;
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h1000_2F00);
    repeat (4) @(posedge pclk);
    chk({28'h0, lfi}, 32'h4);
    amp <= 8'hFF;
    refp <= 4'hF;
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h1000_0B00);
    wait_lfi(4'hB, 20);
    chk({24'h0, pwr, rat}, 32'h0000_00B0);
  endtask
  task automatic t_trans();
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h1000_0F00);
    // channel two just re-enabled: its fault output settles first
    wait_lfi(4'hF, 17000);
    still <= 1'b1;
    // sixty repeats fault, one cycle to register the output
    repeat (63) @(posedge pclk);
    chk({28'h0, lfi}, 32'hF);
    @(posedge pclk);
    chk({28'h0, lfi}, 32'h0);
    apb(1'b0, lfm_pkg::STAT_OFS, 32'h0);
    chk({28'h0, rd[15:12]}, 32'hF);
    // host swaps to the secondary line, which still toggles
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h1000_0F0F);
    wait_lfi(4'hF, 200);
    still <= 1'b0;
  endtask
  task automatic t_frame();
    // channel zero loops back a repeated full pattern, framer on
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h0011_0F10);
    for (int i = 0; i < 40; i++) begin
      txi <= {3'h0, lfm_pkg::K285_NEG[i % 10]};
      @(posedge pclk);
    end
    apb(1'b0, lfm_pkg::CHAR01_OFS, 32'h0);
    chk({22'h0, rd[9:0]}, {22'h0, lfm_pkg::K285_NEG});
  endtask
  task automatic t_range();
    // power cycle so all channels share one window phase
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h1000_0000);
    apb(1'b1, lfm_pkg::CTRL_OFS, 32'h1000_0F00);
    ref_on <= 1'b0;
    n = 0;
    while (trk[0] !== 1'b1 && n < 17000) begin
      @(posedge pclk);
      n++;
    end
    chk({28'h0, trk}, 32'hF);
    @(posedge pclk);
    chk({28'h0, lfi}, 32'h0);
    apb(1'b0, lfm_pkg::STAT_OFS, 32'h0);
    chk({28'h0, rd[7:4]}, 32'hF);
    ref_on <= 1'b1;
    n = 4;
    while (trk[0] === 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= 16376 && n <= 16392}, 32'h1);
    wait_lfi(4'hF, 17000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    // range scenario needs about three intervals of 16384 cycles
    repeat (60000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    txi = 4'h0;
    amp = 8'hFF;
    refp = 4'hF;
    still = 1'b0;
    ref_on = 1'b1;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_route();
    t_amp();
    t_link();
    t_trans();
    t_range();
    t_frame();
    end_sim();
  end
endmodule // test_rx_link_fault_monitor
`default_nettype wire
